// ===== shared/dds_pkg.sv
package dds_pkg;
  // ---------------------------------------------------------------
  // serial register addresses and widths in bits
  // ---------------------------------------------------------------
  localparam logic [4:0] ADDR_CW_ONE = 5'h00;
  localparam logic [4:0] ADDR_CW_TWO = 5'h01;
  localparam logic [4:0] ADDR_FREQ   = 5'h04;
  localparam logic [4:0] ADDR_PHASE  = 5'h05;
  localparam logic [5:0] W_CW_ONE    = 6'h20;
  localparam logic [5:0] W_CW_TWO    = 6'h18;
  localparam logic [5:0] W_FREQ      = 6'h20;
  localparam logic [5:0] W_PHASE     = 6'h10;
  localparam logic [5:0] W_UNMAPPED  = 6'h08;
  localparam logic [5:0] INSTR_BITS  = 6'h08;
  localparam logic [5:0] CNT_MAX     = 6'h3F;
  localparam int         INSTR_RD    = 7;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] CW_ONE_RST   = 32'h0000_2000;
  localparam logic [31:0] PEND_ONE_RST = 32'h0000_0000;
  localparam logic [23:0] CW_TWO_RST   = 24'h18_0000;
  localparam logic [31:0] FREQ_RST     = 32'h0000_0000;
  localparam logic [15:0] PHASE_RST    = 16'h0000;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ONE_CLR_A     = 13;
  localparam int ONE_CLR_B     = 8;
  localparam int ONE_IN_ONLY   = 9;
  localparam int ONE_COMP_PD   = 6;
  localparam int ONE_BUF_OFF   = 4;
  localparam int ONE_LSB_FIRST = 0;
  localparam int TWO_XTAL_OUT  = 9;
  localparam int TWO_MULT_MSB  = 7;
  localparam int TWO_MULT_LSB  = 3;
  localparam logic [4:0] MULT_MIN    = 5'h04;
  localparam logic [4:0] MULT_MAX    = 5'h14;
  localparam logic [4:0] MULT_BYPASS = 5'h01;
  // ---------------------------------------------------------------
  // phase and amplitude
  // ---------------------------------------------------------------
  localparam logic [13:0] QUARTER    = 14'h1000;
  localparam logic [12:0] HALF_TOP   = 13'h1FFF;
endpackage

// ===== src/dds_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 32-bit accumulator adds frequency step each clock
// - phase maps through cosine to converter sample
// - 14-bit phase shift added to phase
// - zero words freeze or keep phase only
// - control word one bits 13, 8 clear accumulator
// - active clear set, pending clear at reset
// - multiplier field 4..20 multiplies reference
// - other multiplier values bypass and stop multiplier
// - select pin enables oscillator, else external reference
// - bit 4 stops core clock, oscillator runs
// - control word two bit 9 enables oscillator output while select pin is high
// - multiplier independent of input buffer disable
// - bit 6 powers comparator down
// - serial port supports msb and lsb first
// - serial port two-wire or three-wire
// - every register readable and writable serially
// - abort input ends serial transfer immediately
// - active low select; ignore bus when high
module dds_core (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_sclk,
  input  wire logic        i_cs_n,
  input  wire logic        i_serial_abort,
  input  wire logic        i_sdio_in,
  output logic             o_sdio_out,
  output logic             o_sdio_oe,
  output logic             o_serial_data_out,
  output logic             o_serial_data_out_oe,
  input  wire logic        i_io_update,
  input  wire logic        i_oscillator_select_pin,
  output logic [13:0]      o_dac_sample,
  output logic             o_osc_enable,
  output logic             o_osc_out_buf_enable,
  output logic             o_clk_in_buf_enable,
  output logic             o_pll_enable,
  output logic [4:0]       o_pll_mult,
  output logic             o_core_clock_run,
  output logic             o_comparator_enable
);
  // ---------------------------------------------------------------
  // serial link domain
  // ---------------------------------------------------------------
  logic        frame_rst;
  logic [5:0]  cnt_q;
  logic [7:0]  instr_q;
  logic [7:0]  instr_d;
  logic [31:0] sh_q;
  logic [31:0] sh_d;
  logic [31:0] word_in;
  logic [5:0]  width;
  logic [5:0]  k;
  logic [5:0]  idx;
  logic [31:0] rd_word;
  logic        in_data;
  logic        commit;
  logic [1:0]  lsb_sync_q;
  logic [1:0]  only_sync_q;
  logic        lsb;
  logic        in_only;
  logic        out_q;
  logic        oe_q;
  logic        wr_tgl_q;
  logic [31:0] pend_word_one_q;
  logic [23:0] pend_word_two_q;
  logic [31:0] pend_freq_q;
  logic [15:0] pend_phase_q;
  logic [31:0] control_word_one_q;

  // abort or deselect resets the frame without needing a link edge
  assign frame_rst = i_cs_n | i_serial_abort;

  // ordering and wire count come from the active word; they are
  // quasi-static, so a two-stage synchroniser on the link clock suffices
  always_ff @(posedge i_sclk or posedge i_srst) begin
    if (i_srst) begin
      lsb_sync_q  <= 2'h0;
      only_sync_q <= 2'h0;
    end else begin
      lsb_sync_q  <= {lsb_sync_q[0],
                      control_word_one_q[dds_pkg::ONE_LSB_FIRST]};
      only_sync_q <= {only_sync_q[0],
                      control_word_one_q[dds_pkg::ONE_IN_ONLY]};
    end
  end
  assign lsb     = lsb_sync_q[1];
  assign in_only = only_sync_q[1];

  always_comb begin
    if (instr_q[4:0] == dds_pkg::ADDR_CW_ONE) begin
      width   = dds_pkg::W_CW_ONE;
      rd_word = pend_word_one_q;
    end else if (instr_q[4:0] == dds_pkg::ADDR_CW_TWO) begin
      width   = dds_pkg::W_CW_TWO;
      rd_word = {8'h00, pend_word_two_q};
    end else if (instr_q[4:0] == dds_pkg::ADDR_FREQ) begin
      width   = dds_pkg::W_FREQ;
      rd_word = pend_freq_q;
    end else if (instr_q[4:0] == dds_pkg::ADDR_PHASE) begin
      width   = dds_pkg::W_PHASE;
      rd_word = {16'h0000, pend_phase_q};
    end else begin
      width   = dds_pkg::W_UNMAPPED;
      rd_word = 32'h0000_0000;
    end
  end

  assign in_data = (cnt_q >= dds_pkg::INSTR_BITS);
  assign k       = cnt_q - dds_pkg::INSTR_BITS;
  assign idx     = lsb ? k : (width - 6'h01 - k);

  always_comb begin
    instr_d = instr_q;
    sh_d    = sh_q;
    if (!in_data) begin
      instr_d = lsb ? {i_sdio_in, instr_q[7:1]}
                    : {instr_q[6:0], i_sdio_in};
    end else begin
      sh_d = lsb ? {i_sdio_in, sh_q[31:1]}
                 : {sh_q[30:0], i_sdio_in};
    end
  end
  assign word_in = lsb ? (sh_d >> (6'h20 - width)) : sh_d;
  assign commit  = in_data && !instr_q[dds_pkg::INSTR_RD] &&
                   (k == width - 6'h01);

  always_ff @(posedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      cnt_q   <= 6'h00;
      instr_q <= 8'h00;
      sh_q    <= 32'h0000_0000;
    end else begin
      if (cnt_q != dds_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + 6'h01;
      end
      instr_q <= instr_d;
      sh_q    <= sh_d;
    end
  end

  // pending copies; nothing here reaches the datapath until apply
  always_ff @(posedge i_sclk or posedge i_srst) begin
    if (i_srst) begin
      pend_word_one_q <= dds_pkg::PEND_ONE_RST;
      pend_word_two_q <= dds_pkg::CW_TWO_RST;
      pend_freq_q     <= dds_pkg::FREQ_RST;
      pend_phase_q    <= dds_pkg::PHASE_RST;
      wr_tgl_q        <= 1'b0;
    end else if (commit && !frame_rst) begin
      wr_tgl_q <= ~wr_tgl_q;
      if (instr_q[4:0] == dds_pkg::ADDR_CW_ONE) begin
        pend_word_one_q <= word_in;
      end else if (instr_q[4:0] == dds_pkg::ADDR_CW_TWO) begin
        pend_word_two_q <= word_in[23:0];
      end else if (instr_q[4:0] == dds_pkg::ADDR_FREQ) begin
        pend_freq_q <= word_in;
      end else if (instr_q[4:0] == dds_pkg::ADDR_PHASE) begin
        pend_phase_q <= word_in[15:0];
      end
    end
  end

  // read data launched on the falling edge, sampled by host on rise
  always_ff @(negedge i_sclk or posedge frame_rst) begin
    if (frame_rst) begin
      out_q <= 1'b0;
      oe_q  <= 1'b0;
    end else begin
      oe_q  <= in_data && instr_q[dds_pkg::INSTR_RD] && (k < width);
      out_q <= rd_word[idx[4:0]];
    end
  end
  assign o_sdio_out           = out_q;
  assign o_sdio_oe            = oe_q & ~in_only;
  assign o_serial_data_out    = out_q;
  assign o_serial_data_out_oe = oe_q & in_only;

  // ---------------------------------------------------------------
  // core clock domain: crossings and settings
  // ---------------------------------------------------------------
  logic [2:0]  tgl_sync_q;
  logic [2:0]  upd_sync_q;
  logic [1:0]  osc_sync_q;
  logic [31:0] stage_one_q;
  logic [23:0] stage_two_q;
  logic [31:0] stage_freq_q;
  logic [15:0] stage_phase_q;
  logic [23:0] control_word_two_q;
  logic [31:0] freq_step_word_q;
  logic [15:0] phase_shift_word_q;
  logic [4:0]  mult;
  logic        mult_ok;
  logic        clr;
  logic        run;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tgl_sync_q <= 3'h0;
      upd_sync_q <= 3'h0;
      osc_sync_q <= 2'h0;
    end else begin
      tgl_sync_q <= {tgl_sync_q[1:0], wr_tgl_q};
      upd_sync_q <= {upd_sync_q[1:0], i_io_update};
      osc_sync_q <= {osc_sync_q[0], i_oscillator_select_pin};
    end
  end

  // pending words are stable for many core cycles after the toggle
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stage_one_q   <= dds_pkg::PEND_ONE_RST;
      stage_two_q   <= dds_pkg::CW_TWO_RST;
      stage_freq_q  <= dds_pkg::FREQ_RST;
      stage_phase_q <= dds_pkg::PHASE_RST;
    end else if (tgl_sync_q[2] != tgl_sync_q[1]) begin
      stage_one_q   <= pend_word_one_q;
      stage_two_q   <= pend_word_two_q;
      stage_freq_q  <= pend_freq_q;
      stage_phase_q <= pend_phase_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      control_word_one_q <= dds_pkg::CW_ONE_RST;
      control_word_two_q <= dds_pkg::CW_TWO_RST;
      freq_step_word_q   <= dds_pkg::FREQ_RST;
      phase_shift_word_q <= dds_pkg::PHASE_RST;
    end else if (upd_sync_q[1] && !upd_sync_q[2]) begin
      control_word_one_q <= stage_one_q;
      control_word_two_q <= stage_two_q;
      freq_step_word_q   <= stage_freq_q;
      phase_shift_word_q <= stage_phase_q;
    end
  end

  assign mult    = control_word_two_q[dds_pkg::TWO_MULT_MSB:
                                      dds_pkg::TWO_MULT_LSB];
  assign mult_ok = (mult >= dds_pkg::MULT_MIN) &&
                   (mult <= dds_pkg::MULT_MAX);
  assign clr     = control_word_one_q[dds_pkg::ONE_CLR_A] |
                   control_word_one_q[dds_pkg::ONE_CLR_B];
  assign run     = ~control_word_one_q[dds_pkg::ONE_BUF_OFF];

  // multiplier decode does not look at the buffer bit at all
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_pll_enable         <= 1'b0;
      o_pll_mult           <= dds_pkg::MULT_BYPASS;
      o_osc_enable         <= 1'b0;
      o_osc_out_buf_enable <= 1'b0;
      o_clk_in_buf_enable  <= 1'b1;
      o_core_clock_run     <= 1'b1;
      o_comparator_enable  <= 1'b1;
    end else begin
      o_pll_enable <= mult_ok;
      o_pll_mult   <= mult_ok ? mult : dds_pkg::MULT_BYPASS;
      o_osc_enable <= osc_sync_q[1];
      o_osc_out_buf_enable <= osc_sync_q[1] &
        control_word_two_q[dds_pkg::TWO_XTAL_OUT];
      // the oscillator stays up while the buffer is off: restart is slow
      o_clk_in_buf_enable  <= run;
      o_core_clock_run     <= run;
      o_comparator_enable  <=
        ~control_word_one_q[dds_pkg::ONE_COMP_PD];
    end
  end

  // ---------------------------------------------------------------
  // phase accumulator and cosine mapping
  // ---------------------------------------------------------------
  logic [31:0] acc_q;
  logic [13:0] phase;
  logic [13:0] cphase;
  logic [12:0] h;
  logic [25:0] prod;
  logic [13:0] mag;

  // a stopped core clock is modelled by holding the accumulator
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      acc_q <= 32'h0000_0000;
    end else if (clr) begin
      acc_q <= 32'h0000_0000;
    end else if (run) begin
      acc_q <= acc_q + freq_step_word_q;
    end
  end

  assign phase  = (clr ? 14'h0000 : acc_q[31:18]) +
                  phase_shift_word_q[13:0];
  // parabolic half-wave, a quarter turn ahead, approximates cosine
  assign cphase = phase + dds_pkg::QUARTER;
  assign h      = cphase[12:0];
  assign prod   = 26'(h) * 26'(dds_pkg::HALF_TOP - h);
  assign mag    = {1'b0, prod[23:11]};

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_dac_sample <= 14'h0000;
    end else if (run) begin
      o_dac_sample <= cphase[13] ? 14'(-mag) : mag;
    end
  end
endmodule
`default_nettype wire

// ===== verif/dds_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
module dds_core_sva (
  input wire logic        i_clk,
  input wire logic        i_srst,
  input wire logic        i_cs_n,
  input wire logic        i_serial_abort,
  input wire logic        i_oscillator_select_pin,
  input wire logic        o_sdio_oe,
  input wire logic        o_serial_data_out_oe,
  input wire logic [13:0] o_dac_sample,
  input wire logic        o_osc_enable,
  input wire logic        o_osc_out_buf_enable,
  input wire logic        o_pll_enable,
  input wire logic [4:0]  o_pll_mult,
  input wire logic        o_core_clock_run
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  // select pin passes two sync flops and a register
  sequence sel_settled;
    $stable(i_oscillator_select_pin) [*8];
  endsequence
  sequence stopped;
    !o_core_clock_run [*3];
  endsequence
  a_pll_range: assert property (o_pll_enable |->
    o_pll_mult >= 5'h04 && o_pll_mult <= 5'h14) else $error("pll range");
  a_pll_bypass: assert property (!o_pll_enable |->
    o_pll_mult == 5'h01) else $error("bypass mult");
  a_osc_follow: assert property (sel_settled |->
    o_osc_enable == i_oscillator_select_pin) else $error("osc follow");
  a_osc_buf_gate: assert property (o_osc_out_buf_enable |->
    o_osc_enable) else $error("osc buffer");
  a_dac_frozen: assert property (stopped |->
    $stable(o_dac_sample)) else $error("dac moved");
  a_oe_exclusive: assert property (!(o_sdio_oe &&
    o_serial_data_out_oe)) else $error("two drivers");
  a_cs_quiet: assert property (i_cs_n [*2] |->
    !o_sdio_oe && !o_serial_data_out_oe) else $error("cs drive");
  a_abort_quiet: assert property (i_serial_abort [*2] |->
    !o_sdio_oe && !o_serial_data_out_oe) else $error("abort drive");
  a_reset_vals: assert property (disable iff (1'b0) i_srst |=>
    o_dac_sample == 14'h0000 && o_pll_mult == 5'h01 && o_core_clock_run)
    else $error("reset values");
endmodule
bind dds_core dds_core_sva chk_u (
  .i_clk                  (i_clk),
  .i_srst                 (i_srst),
  .i_cs_n                 (i_cs_n),
  .i_serial_abort         (i_serial_abort),
  .i_oscillator_select_pin(i_oscillator_select_pin),
  .o_sdio_oe              (o_sdio_oe),
  .o_serial_data_out_oe   (o_serial_data_out_oe),
  .o_dac_sample           (o_dac_sample),
  .o_osc_enable           (o_osc_enable),
  .o_osc_out_buf_enable   (o_osc_out_buf_enable),
  .o_pll_enable           (o_pll_enable),
  .o_pll_mult             (o_pll_mult),
  .o_core_clock_run       (o_core_clock_run)
);
`default_nettype wire

// ===== verif/dds_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dds_host_model (
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_abort,
  output logic      o_sdio,
  input  wire logic i_sdio_out,
  input  wire logic i_sdio_oe,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  logic lsb;
  logic three;
  logic drv;
  logic bit_q;
  logic last_q;
  // ---------------------------------------------------------------
  // two-wire data pin
  // ---------------------------------------------------------------
  // released pin shows the inverse of its last value, never a kind 0
  assign o_sdio = i_sdio_oe ? i_sdio_out
                            : (drv ? bit_q : ~last_q);
  always @(posedge o_sclk) last_q <= o_sdio;
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_abort = 1'b0;
    lsb = 1'b0;
    three = 1'b0;
    drv = 1'b0;
    bit_q = 1'b0;
    last_q = 1'b0;
  end
  // in this task sclk runs only inside a frame, 15 ns period
  task automatic xfer(input logic rd, input logic [4:0] a, input int n,
                      input logic [31:0] d, input int cut,
                      output logic [31:0] q);
    logic [7:0] ins;
    int i;
    ins = {rd, 2'b00, a};
    q = 32'h0000_0000;
    o_cs_n = 1'b0;
    for (i = 0; i < n + 8; i++) begin
      if (i == cut && cut > 0) begin
        o_abort = 1'b1;
        break;
      end
      drv = !(rd && i >= 8);
      if (i < 8) bit_q = lsb ? ins[i] : ins[7 - i];
      else bit_q = lsb ? d[i - 8] : d[n + 7 - i];
      // a read bit is launched on the previous fall, so it is taken
      // just before the rise; an idle output pin shows as unknown
      #3.75;
      if (!drv) begin
        q[lsb ? i - 8 : n + 7 - i] =
          three ? (i_sdo_oe ? i_sdo : 1'bx) : o_sdio;
      end
      o_sclk = 1'b1;
      #7.5 o_sclk = 1'b0;
      #3.75;
    end
    drv = 1'b0;
    o_cs_n = 1'b1;
    #20;
    o_abort = 1'b0;
  endtask
  // link edges with the select high: the device ignores the bus, but
  // its ordering and wire-count synchronisers move on
  task automatic idle_clk(input int n);
    repeat (n) begin
      #3.75 o_sclk = 1'b1;
      #7.5 o_sclk = 1'b0;
      #3.75;
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/dds_core_clock_config_test.sv
`timescale 1ns/1ps
`default_nettype none
module dds_core_clock_config_test;
  typedef struct packed {
    logic [4:0] mult;
    logic       en;
    logic [4:0] eff;
  } row_s;
  row_s rows [7] = '{{5'h00, 1'b0, 5'h01}, {5'h03, 1'b0, 5'h01},
    {5'h04, 1'b1, 5'h04}, {5'h14, 1'b1, 5'h14}, {5'h15, 1'b0, 5'h01},
    {5'h1F, 1'b0, 5'h01}, {5'h0A, 1'b1, 5'h0A}};
  logic clk, srst, upd, sel;
  wire logic sclk, cs_n, abort, sdio_in, sdio_out, sdio_oe, serial_data_out, sdo_oe;
  wire logic osc, osc_buf, cib, pll_en, run, comp;
  wire logic [13:0] dac;
  wire logic [4:0] mult;
  int failures, samples_checked, i;
  logic [31:0] q;
  logic [13:0] d0, dz;
  dds_core dut_u (.i_clk(clk), .i_srst(srst), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_serial_abort(abort), .i_sdio_in(sdio_in), .o_sdio_out(sdio_out),
    .o_sdio_oe(sdio_oe), .o_serial_data_out(serial_data_out),
    .o_serial_data_out_oe(sdo_oe), .i_io_update(upd),
    .i_oscillator_select_pin(sel), .o_dac_sample(dac), .o_osc_enable(osc),
    .o_osc_out_buf_enable(osc_buf), .o_clk_in_buf_enable(cib),
    .o_pll_enable(pll_en), .o_pll_mult(mult), .o_core_clock_run(run),
    .o_comparator_enable(comp));
  dds_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_abort(abort),
    .o_sdio(sdio_in), .i_sdio_out(sdio_out), .i_sdio_oe(sdio_oe),
    .i_sdo(serial_data_out), .i_sdo_oe(sdo_oe));
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic apply();
    tick(6);
    upd = 1'b1;
    tick(3);
    upd = 1'b0;
    tick(6);
  endtask
  task automatic wr(input logic [4:0] a, input int n, input logic [31:0] d);
    host_u.xfer(1'b0, a, n, d, 0, q);
  endtask
  task automatic rd(input logic [4:0] a, input int n);
    host_u.xfer(1'b1, a, n, 32'h0, 0, q);
  endtask
  task automatic wrap_up();
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
  initial begin
    failures = 0;
    samples_checked = 0;
    srst = 1'b1;
    upd = 1'b0;
    sel = 1'b0;
    tick(6);
    srst = 1'b0;
    tick(2);
    chk("comp", comp, 1'b1);
    wr(dds_pkg::ADDR_FREQ, 32, 32'h4000_0000);
    dz = dac;
    tick(5);
    chk("dac_pend", dac, dz);
    chk("dac_sign", {dz[13], dz != 14'h0000}, 2'b01);
    apply();
    d0 = dac;
    tick(1);
    chk("dac_step", dac != d0, 1'b1);
    tick(3);
    chk("dac_period", dac, d0);
    wr(dds_pkg::ADDR_FREQ, 32, 32'h0);
    apply();
    d0 = dac;
    tick(3);
    chk("dac_hold", dac, d0);
    wr(dds_pkg::ADDR_FREQ, 32, 32'h4000_0000);
    for (i = 8; i <= 13; i += 5) begin
      wr(dds_pkg::ADDR_CW_ONE, 32, 32'h1 << i);
      apply();
      chk("dac_clear", dac, dz);
    end
    wr(dds_pkg::ADDR_PHASE, 16, 32'h2000);
    apply();
    chk("dac_half", dac[13], 1'b1);
    // lock time and multiplied rate are analog
    // the bench keeps to settings and reads them back only
    for (i = 0; i < 7; i++) begin
      wr(dds_pkg::ADDR_CW_TWO, 24, {16'h1802, rows[i].mult, 3'b000});
      rd(dds_pkg::ADDR_CW_TWO, 24);
      chk("cw_two", q, {16'h1802, rows[i].mult, 3'b000});
      apply();
      chk("pll_en", pll_en, rows[i].en);
      chk("pll_mult", mult, rows[i].eff);
    end
    sel = 1'b1;
    tick(6);
    chk("osc_on", {osc, osc_buf}, 2'b11);
    sel = 1'b0;
    tick(6);
    chk("osc_off", {osc, osc_buf}, 2'b00);
    wr(dds_pkg::ADDR_CW_ONE, 32, 32'h50);
    apply();
    chk("clk_ctl", {run, cib, comp, pll_en},
        4'b0001);
    host_u.xfer(1'b0, dds_pkg::ADDR_FREQ, 32, 32'h1234_5678, 12, q);
    rd(dds_pkg::ADDR_FREQ, 32);
    chk("freq_abort", q, 32'h4000_0000);
    wr(5'h02, 8, 32'hFF);
    rd(5'h02, 8);
    chk("unmapped", q, 32'h0);
    wr(dds_pkg::ADDR_CW_ONE, 32, 32'h201);
    apply();
    // the new ordering reaches the link logic only on link edges
    host_u.idle_clk(3);
    host_u.lsb = 1'b1;
    host_u.three = 1'b1;
    wr(dds_pkg::ADDR_PHASE, 16, 32'h1234);
    rd(dds_pkg::ADDR_PHASE, 16);
    chk("lsb_3w", q, 32'h1234);
    srst = 1'b1;
    tick(6);
    srst = 1'b0;
    tick(2);
    host_u.lsb = 1'b0;
    host_u.three = 1'b0;
    rd(dds_pkg::ADDR_FREQ, 32);
    chk("freq_rst", q, 32'h0);
    chk("mult_rst", mult, 5'h01);
    wrap_up();
  end
endmodule
`default_nettype wire
